/* tmc_pkg.sv */
// Constants shared by the thermal monitor and current compensation block
package tmc_pkg;

    // ------------------------------------------------------------------
    // Command codes and register reset values
    // ------------------------------------------------------------------
    localparam logic [7:0] TMC_CMD_LIMIT      = 8'he8;
    localparam logic [7:0] TMC_CMD_COMP       = 8'he9;
    localparam logic [7:0] TMC_LIMIT_RST      = 8'h03;  // 100 degree limit
    localparam logic [7:0] TMC_COMP_RST       = 8'h00;  // Compensation off
    localparam logic [3:0] TMC_COMP_OFF       = 4'h0;
    localparam int         TMC_LIMIT_LSB      = 0;
    localparam int         TMC_LIMIT_W        = 3;
    localparam int         TMC_COMP_LSB       = 0;
    localparam int         TMC_COMP_W         = 4;

    // ------------------------------------------------------------------
    // Ratio of sense voltage to supply, in hundredths of a percent
    // ------------------------------------------------------------------
    localparam int TMC_RATIO_W = 14;

    // Alarm assert levels, index 0 = 85 degrees .. 7 = 120 degrees
    localparam logic [7:0][13:0] TMC_HOT_ASSERT = {
        14'h0b08, 14'h0bfc, 14'h0d04, 14'h0e1e,
        14'h0f48, 14'h1082, 14'h11c8, 14'h131e};
    // Alarm release levels, same indexing
    localparam logic [7:0][13:0] TMC_HOT_RELEASE = {
        14'h0b9a, 14'h0c98, 14'h0dac, 14'h0ed0,
        14'h1002, 14'h1144, 14'h1294, 14'h13f0};

    // Converter breakpoints every 16 degrees, index 0 = 0 degrees
    localparam logic [8:0][13:0] TMC_CONV_BP = {
        14'h09e9, 14'h0cd0, 14'h105f, 14'h1484, 14'h18ef,
        14'h1d2c, 14'h20c4, 14'h2370, 14'h252e};
    localparam int         TMC_CODE_W         = 6;
    localparam logic [5:0] TMC_CODE_MAX       = 6'h3f;
    localparam logic [5:0] TMC_CODE_RST       = 6'h0c;  // About 24 degrees
    localparam int         TMC_SEG_SHIFT      = 3;

    // ------------------------------------------------------------------
    // Sense undervoltage thresholds in millivolts
    // ------------------------------------------------------------------
    localparam int          TMC_MV_W          = 12;
    localparam logic [11:0] TMC_UV_TRIP_MV    = 12'h3b6;  // 950 mV
    localparam logic [11:0] TMC_UV_CLEAR_MV   = 12'h41a;  // 1050 mV

    // ------------------------------------------------------------------
    // Gain arithmetic, temperatures in tenths of a degree, gain in Q16
    // ------------------------------------------------------------------
    localparam logic signed [19:0] TMC_TENTHS_PER_CODE = 20'sh00014;
    localparam logic signed [19:0] TMC_REF_TENTHS      = 20'sh000fa;
    localparam logic signed [19:0] TMC_SLOPE_Q16       = 20'sh00019;
    localparam logic signed [19:0] TMC_GAIN_ONE        = 20'sh10000;
    localparam int                 TMC_GAIN_W          = 18;
    localparam int                 TMC_GAIN_FRAC       = 16;

    // Offset per compensation code in tenths of a degree
    localparam logic [15:0][11:0] TMC_COMP_TENTHS = {
        12'h15f, 12'h144, 12'h129, 12'h10e, 12'h0f3, 12'h0d8,
        12'h0bd, 12'h0a0, 12'h082, 12'h064, 12'h046, 12'h032,
        12'h019, 12'h000, 12'hfe7, 12'h000};

endpackage

/* tmc_tcode.sv */
// Tracking non-linear converter from sense ratio to a 6-bit temperature code
`timescale 1ns/10ps

module tmc_tcode
    import tmc_pkg::*;
(
    // Clock and reset
    input  wire logic                   ref_clk,
    input  wire logic                   rst,
    // Sense ratio in
    input  wire logic [TMC_RATIO_W-1:0] ratio,
    // Temperature code out, two degrees per step
    output logic      [TMC_CODE_W-1:0]  tcode
);

    typedef struct packed {
        logic [TMC_CODE_W-1:0] code;
    } tmc_tc_state_t;

    tmc_tc_state_t st_r;
    tmc_tc_state_t st_nxt;

    // ------------------------------------------------------------------
    // Ratio at the upper edge of a code, interpolated inside a segment
    // ------------------------------------------------------------------
    function automatic logic [TMC_RATIO_W-1:0] code_thr(
        input logic [TMC_CODE_W-1:0] c);
        logic [2:0]             seg;
        logic [2:0]             frac;
        logic [TMC_RATIO_W-1:0] span;
        logic [16:0]            step;
        seg  = c[5:3];
        frac = c[2:0];
        span = TMC_CONV_BP[seg] - TMC_CONV_BP[4'(seg) + 4'h1];
        step = 17'(span) * 17'(frac);
        code_thr = TMC_CONV_BP[seg] - 14'(step >> TMC_SEG_SHIFT);
    endfunction

    // Step the code one count toward the sensed temperature
    always_comb begin
        st_nxt = st_r;
        // [RQ8] linear in temperature
        if (st_r.code != TMC_CODE_MAX &&
            ratio < code_thr(st_r.code + 6'h01)) begin
            st_nxt.code = st_r.code + 6'h01;
        end else if (st_r.code != 6'h00 && ratio > code_thr(st_r.code)) begin
            st_nxt.code = st_r.code - 6'h01;
        end
    end

    // State register
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            st_r.code <= TMC_CODE_RST;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign tcode = st_r.code;

endmodule

/* tmc_thermal.sv */
// Thermal alarm, sense undervoltage shutdown and current temperature gain
`timescale 1ns/10ps

// Summary of operation
// [RQ1] Alarm carries meaning only while the controller is enabled.
// [RQ2] Alarm pin is open drain: driven low when asserted, else released.
// [RQ3] Alarm threshold comes from limit bits [2:0], compared with hysteresis.
// [RQ4] At 100 degrees assert below 39.12% supply, release above 40.98%.
// [RQ5] Eight limits, 85 to 120 degrees, each with a higher release level.
// [RQ6] Disable controller below 0.95 V sense, re-enable above 1.05 V.
// [RQ7] Sense ratio to supply is converted to a 6-bit temperature code.
// [RQ8] Conversion is non-linear so the code is linear in temperature.
// [RQ9] Offset plus temperature code selects a gain for every channel current.
// [RQ10] Droop and overcurrent use the compensated currents, not raw ones.
// [RQ11] Offset code 0 turns compensation off; 1..f pick -2.5 to 35.1 degrees.
// [RQ12] Gain cancels about +0.385% per degree of sense resistance drift.
// [RQ13] Regulator ready drops while the sense undervoltage shutdown holds.
// [RQ14] Limit codes ascend 85..120; alarm holds between its two levels.

module tmc_thermal
    import tmc_pkg::*;
#(
    parameter int N_CH  = 6,
    parameter int CUR_W = 12
)(
    // Clock and reset
    input  wire logic                          ref_clk,
    input  wire logic                          rst,
    // Sense inputs
    input  wire logic [TMC_RATIO_W-1:0]        temp_sense_input,
    input  wire logic [TMC_MV_W-1:0]           temp_sense_mv,
    // Controller state
    input  wire logic                          ctrl_enable,
    input  wire logic                          ready_request,
    // Command port
    input  wire logic                          cmd_wr,
    input  wire logic                          cmd_rd,
    input  wire logic [7:0]                    cmd_code,
    input  wire logic [7:0]                    cmd_wdata,
    output logic      [7:0]                    cmd_rdata,
    // Open-drain alarm pin
    input  wire logic                          thermal_alarm_n_i,
    output logic                               thermal_alarm_n_o,
    output logic                               thermal_alarm_n_oe,
    output logic                               thermal_alarm_valid,
    // Controller shutdown and ready
    output logic                               temp_sense_shutdown_reset,
    output logic                               regulator_ready,
    // Channel currents
    input  wire logic [N_CH-1:0][CUR_W-1:0]    chan_current_raw,
    input  wire logic [CUR_W+$clog2(N_CH)-1:0] ocp_sum_limit,
    output logic      [N_CH-1:0][CUR_W-1:0]    chan_current_comp,
    output logic      [CUR_W+$clog2(N_CH)-1:0] droop_current,
    output logic                               ocp_trip,
    // Temperature telemetry
    output logic      [TMC_CODE_W-1:0]         temp_code,
    output logic      [TMC_GAIN_W-1:0]         comp_gain
);

    localparam int SUM_W    = CUR_W + $clog2(N_CH);
    // Width of a scaled current before saturation
    localparam int PROD_Q_W = CUR_W + TMC_GAIN_W - TMC_GAIN_FRAC;

    typedef struct packed {
        logic [7:0]                 limit;
        logic [7:0]                 comp;
        logic [7:0]                 rdata;
        logic                       alarm;
        logic                       drv_lvl;
        logic                       valid;
        logic                       shutdown;
        logic                       ready;
        logic [TMC_GAIN_W-1:0]      gain;
        logic [N_CH-1:0][CUR_W-1:0] cur;
        logic [SUM_W-1:0]           sum;
        logic                       ocp;
    } tmc_state_t;

    tmc_state_t              st_r;
    tmc_state_t              st_nxt;
    logic [TMC_CODE_W-1:0]   tcode;
    logic [TMC_LIMIT_W-1:0]  lim_sel;
    logic [TMC_COMP_W-1:0]   comp_sel;
    logic signed [19:0]      t_code;
    logic signed [19:0]      t_off;
    logic signed [19:0]      delta;
    logic signed [19:0]      gain_s;
    logic [SUM_W-1:0]        sum_v;

    // ------------------------------------------------------------------
    // Temperature code converter
    // ------------------------------------------------------------------
    // [RQ7] ratio to 6-bit code
    tmc_tcode u_tcode (
        .ref_clk (ref_clk),
        .rst     (rst),
        .ratio   (temp_sense_input),
        .tcode   (tcode)
    );

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    // Scale one current by the Q16 gain, saturating at full scale
    function automatic logic [CUR_W-1:0] scale_cur(
        input logic [CUR_W-1:0]      c,
        input logic [TMC_GAIN_W-1:0] g);
        logic [CUR_W+TMC_GAIN_W-1:0] p;
        logic [PROD_Q_W-1:0]         q;
        p = (CUR_W+TMC_GAIN_W)'(c) * (CUR_W+TMC_GAIN_W)'(g);
        q = p[CUR_W+TMC_GAIN_W-1:TMC_GAIN_FRAC];
        if (q > PROD_Q_W'({CUR_W{1'b1}})) begin
            scale_cur = {CUR_W{1'b1}};
        end else begin
            scale_cur = q[CUR_W-1:0];
        end
    endfunction

    // Register field selects
    assign lim_sel  = st_r.limit[TMC_LIMIT_LSB +: TMC_LIMIT_W];
    assign comp_sel = st_r.comp[TMC_COMP_LSB +: TMC_COMP_W];

    // Compensated temperature and gain arithmetic
    always_comb begin
        t_code = $signed({14'h0000, tcode}) * TMC_TENTHS_PER_CODE;
        t_off  = {{8{TMC_COMP_TENTHS[comp_sel][11]}},
                  TMC_COMP_TENTHS[comp_sel]};
        delta  = t_code + t_off - TMC_REF_TENTHS;
        // [RQ12] cancel resistance drift
        gain_s = TMC_GAIN_ONE - delta * TMC_SLOPE_Q16;
    end

    // Droop sum over compensated currents
    always_comb begin
        sum_v = '0;
        for (int i = 0; i < N_CH; i++) begin
            sum_v = sum_v + SUM_W'(st_r.cur[i]);
        end
    end

    // ------------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------------
    always_comb begin
        st_nxt         = st_r;
        st_nxt.drv_lvl = 1'b0;

        // Command writes and registered reads
        if (cmd_wr && cmd_code == TMC_CMD_LIMIT) begin
            st_nxt.limit = cmd_wdata;
        end
        if (cmd_wr && cmd_code == TMC_CMD_COMP) begin
            st_nxt.comp = cmd_wdata;
        end
        if (cmd_rd) begin
            unique case (cmd_code)
                TMC_CMD_LIMIT: st_nxt.rdata = st_r.limit;
                TMC_CMD_COMP:  st_nxt.rdata = st_r.comp;
                default:       st_nxt.rdata = 8'h00;
            endcase
        end

        // [RQ1] alarm only when enabled
        st_nxt.valid = ctrl_enable;
        if (!ctrl_enable) begin
            st_nxt.alarm = 1'b0;
        // [RQ3] [RQ4] [RQ5] selected trip
        end else if (temp_sense_input < TMC_HOT_ASSERT[lim_sel]) begin
            st_nxt.alarm = 1'b1;
        // [RQ14] hold between levels
        end else if (temp_sense_input > TMC_HOT_RELEASE[lim_sel]) begin
            st_nxt.alarm = 1'b0;
        end

        // [RQ6] undervoltage hysteresis
        if (temp_sense_mv < TMC_UV_TRIP_MV) begin
            st_nxt.shutdown = 1'b1;
        end else if (temp_sense_mv > TMC_UV_CLEAR_MV) begin
            st_nxt.shutdown = 1'b0;
        end

        // [RQ13] ready drops on shutdown
        st_nxt.ready = ready_request && ctrl_enable && !st_r.shutdown;

        // [RQ11] code 0 means unity gain
        if (comp_sel == TMC_COMP_OFF) begin
            st_nxt.gain = TMC_GAIN_W'(TMC_GAIN_ONE);
        // [RQ9] offset plus code
        end else begin
            st_nxt.gain = gain_s[TMC_GAIN_W-1:0];
        end

        // Per-channel compensated current
        for (int i = 0; i < N_CH; i++) begin
            st_nxt.cur[i] = scale_cur(chan_current_raw[i], st_r.gain);
        end

        // [RQ10] droop and OCP from compensated
        st_nxt.sum = sum_v;
        st_nxt.ocp = sum_v > ocp_sum_limit;
    end

    // State register
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            st_r          <= '0;
            st_r.limit    <= TMC_LIMIT_RST;
            st_r.comp     <= TMC_COMP_RST;
            st_r.shutdown <= 1'b1;
            st_r.gain     <= TMC_GAIN_W'(TMC_GAIN_ONE);
        end else begin
            st_r <= st_nxt;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    // [RQ2] open-drain pull low
    assign thermal_alarm_n_o         = st_r.drv_lvl;
    assign thermal_alarm_n_oe        = st_r.alarm;
    assign thermal_alarm_valid       = st_r.valid;
    assign temp_sense_shutdown_reset = st_r.shutdown;
    assign regulator_ready           = st_r.ready;
    assign cmd_rdata                 = st_r.rdata;
    assign chan_current_comp         = st_r.cur;
    assign droop_current             = st_r.sum;
    assign ocp_trip                  = st_r.ocp;
    assign temp_code                 = tcode;
    assign comp_gain                 = st_r.gain;

endmodule

/* tmc_thermal_asserts.sv */
// Assertion checker on the thermal monitor ports
`timescale 1ns/10ps

module tmc_thermal_asserts
    import tmc_pkg::*;
(
    // Clock and reset
    input wire logic                   ref_clk,
    input wire logic                   rst,
    // Block inputs
    input wire logic [TMC_RATIO_W-1:0] temp_sense_input,
    input wire logic [TMC_MV_W-1:0]    temp_sense_mv,
    input wire logic                   ctrl_enable,
    input wire logic                   cmd_wr,
    input wire logic [7:0]             cmd_code,
    input wire logic [7:0]             cmd_wdata,
    // Block outputs
    input wire logic                   thermal_alarm_n_o,
    input wire logic                   thermal_alarm_n_oe,
    input wire logic                   temp_sense_shutdown_reset,
    input wire logic                   regulator_ready,
    input wire logic [TMC_CODE_W-1:0]  temp_code,
    input wire logic [TMC_GAIN_W-1:0]  comp_gain
);
    // ----------------------------------------
    // Shadow settings and alarm levels
    // ----------------------------------------
    logic [2:0]  lim_r;
    logic [3:0]  cmp_r;
    wire  [13:0] on_lv  = TMC_HOT_ASSERT[lim_r];
    wire  [13:0] off_lv = TMC_HOT_RELEASE[lim_r];

    // Shadow of the limit and offset writes
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            lim_r <= 3'h3;
            cmp_r <= 4'h0;
        end else if (cmd_wr && cmd_code == 8'he8) begin
            lim_r <= cmd_wdata[2:0];
        end else if (cmd_wr && cmd_code == 8'he9) begin
            cmp_r <= cmd_wdata[3:0];
        end
    end

    // Expected gain from code and offset setting
    function automatic logic [17:0] gain_of(logic [5:0] c, logic [3:0] k);
        int x;
        x = 20 * int'(c) + int'($signed(TMC_COMP_TENTHS[k])) - 250;
        return (k == 4'h0) ? 18'h10000 : 18'(65536 - 25 * x);
    endfunction

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);
    sequence s_hot;  ctrl_enable && temp_sense_input < on_lv;  endsequence
    sequence s_cool; ctrl_enable && temp_sense_input > off_lv; endsequence
    sequence s_band; ctrl_enable && !(temp_sense_input < on_lv)
        && !(temp_sense_input > off_lv); endsequence

    a_alarm_needs_en: assert property (
        !ctrl_enable |=> !thermal_alarm_n_oe) else $error("alarm while off");
    a_pin_low_only: assert property (
        thermal_alarm_n_o == 1'b0) else $error("alarm pin driven high");
    a_hot_asserts: assert property (
        s_hot |=> thermal_alarm_n_oe) else $error("alarm not asserted");
    a_cool_releases: assert property (
        s_cool |=> !thermal_alarm_n_oe) else $error("alarm not released");
    a_band_holds: assert property (
        s_band |=> $stable(thermal_alarm_n_oe)) else $error("alarm moved");
    a_uv_trips: assert property (
        temp_sense_mv < TMC_UV_TRIP_MV |=> temp_sense_shutdown_reset)
        else $error("undervoltage shutdown missed");
    a_uv_clears: assert property (
        temp_sense_mv > TMC_UV_CLEAR_MV |=> !temp_sense_shutdown_reset)
        else $error("undervoltage shutdown stuck");
    a_ready_drops: assert property (
        temp_sense_shutdown_reset |=> !regulator_ready)
        else $error("ready high during shutdown");
    a_code_one_step: assert property (
        $changed(temp_code) |->
        6'(temp_code - $past(temp_code)) inside {6'h01, 6'h3f})
        else $error("temperature code jumped");
    a_gain_follows: assert property (
        !$past(rst) |-> comp_gain == gain_of($past(temp_code), $past(cmp_r)))
        else $error("compensation gain wrong");
endmodule

/* tmc_sense_model.sv */
// Thermistor divider and pulled-up alarm wire facing the block
`timescale 1ns/10ps

module tmc_sense_model
    import tmc_pkg::*;
(
    // Set points from the bench
    input  wire logic [TMC_RATIO_W-1:0] ratio_set,
    input  wire logic [TMC_MV_W-1:0]    mv_set,
    input  wire logic                   alarm_oe,
    // Divider words and alarm wire
    output logic      [TMC_RATIO_W-1:0] temp_sense_input,
    output logic      [TMC_MV_W-1:0]    temp_sense_mv,
    output logic                        alarm_pin_n
);
    // ----------------------------------------
    // Divider and pull-up
    // ----------------------------------------
    // Divider words follow the set points
    assign temp_sense_input = ratio_set;
    assign temp_sense_mv    = mv_set;
    assign alarm_pin_n = alarm_oe ? 1'b0 : 1'b1;
endmodule

/* tmc_thermal_tb.sv */
// Self-checking bench for the thermal monitor block
`timescale 1ns/10ps

module tmc_thermal_tb
    import tmc_pkg::*;
;
    // ----------------------------------------
    // Signals, tables and helpers
    // ----------------------------------------
    logic             ref_clk, rst, ctrl_enable, ready_request;
    logic             cmd_wr, cmd_rd, oe, drv, valid, shut, ready, ocp, pin_n;
    logic [7:0]       cmd_code, cmd_wdata, cmd_rdata;
    logic [13:0]      ratio_set, ratio;
    logic [11:0]      mv_set, mv, e;
    logic [5:0]       tcode;
    logic [17:0]      gain;
    logic [14:0]      ocp_lim, droop;
    logic [5:0][11:0] raw, cur;
    int               n_mismatch = 0, n_compared = 0, s;
    int ON_T[8]   = '{4894, 4552, 4226, 3912, 3614, 3332, 3068, 2824};
    int OFF_T[8]  = '{5104, 4756, 4420, 4098, 3792, 3500, 3224, 2970};
    int BP_T[8]   = '{9518, 9072, 8388, 7468, 6383, 5252, 4191, 3280};
    int OFF10[16] = '{0, -25, 0, 25, 50, 70, 100, 130, 160, 189, 216,
                      243, 270, 297, 324, 351};
    int UV_MV[8]  = '{949, 950, 1050, 1051, 1050, 950, 949, 1051};
    int UV_SD[8]  = '{1, 1, 1, 0, 0, 0, 1, 0};

    function automatic logic [17:0] gain_exp(int c, int k);
        return (k == 0) ? 18'h10000
                        : 18'(65536 - 25 * (20 * c + OFF10[k] - 250));
    endfunction
    function automatic logic [11:0] cur_exp(logic [11:0] r, logic [17:0] g);
        longint p;
        p = (longint'(r) * longint'(g)) >> 16;
        return (p > 4095) ? 12'hfff : 12'(p);
    endfunction
    task automatic chk(string what, logic [31:0] ex, logic [31:0] got);
        n_compared++;
        if (got !== ex) begin
            n_mismatch++;
            $display("ERROR %s expected %0h seen %0h", what, ex, got);
        end
    endtask
    task automatic cyc(int n);
        repeat (n) @(negedge ref_clk);
    endtask
    task automatic wr(logic [7:0] c, logic [7:0] d);
        cmd_wr = 1'b1;
        cmd_code = c;
        cmd_wdata = d;
        cyc(1);
        cmd_wr = 1'b0;
        cyc(1);
    endtask
    task automatic rd_chk(logic [7:0] c, logic [7:0] ex);
        cmd_rd = 1'b1;
        cmd_code = c;
        cyc(1);
        cmd_rd = 1'b0;
        cyc(1);
        chk("cmd_rdata", 32'(ex), 32'(cmd_rdata));
    endtask
    task automatic alarm_step(int r, logic a);
        ratio_set = 14'(r);
        cyc(2);
        chk("thermal_alarm_n_oe", 32'(a), 32'(oe));
        chk("alarm_pin_n", 32'(!a), 32'(pin_n));
        chk("thermal_alarm_n_o", 32'h0, 32'(drv));
    endtask
    task automatic uv_step(int m, int sd);
        mv_set = 12'(m);
        cyc(3);
        chk("temp_sense_shutdown_reset", 32'(sd), 32'(shut));
        chk("regulator_ready", 32'(sd == 0), 32'(ready));
    endtask
    task automatic tally_and_finish();
        $display("Compared %0d, mismatched %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // Partner and design
    tmc_sense_model u_tmc_sense_model (.ratio_set(ratio_set),
        .mv_set(mv_set), .alarm_oe(oe), .temp_sense_input(ratio),
        .temp_sense_mv(mv), .alarm_pin_n(pin_n));
    tmc_thermal u_tmc_thermal (.ref_clk(ref_clk), .rst(rst),
        .temp_sense_input(ratio), .temp_sense_mv(mv),
        .ctrl_enable(ctrl_enable), .ready_request(ready_request),
        .cmd_wr(cmd_wr), .cmd_rd(cmd_rd), .cmd_code(cmd_code),
        .cmd_wdata(cmd_wdata), .cmd_rdata(cmd_rdata),
        .thermal_alarm_n_i(pin_n), .thermal_alarm_n_o(drv),
        .thermal_alarm_n_oe(oe), .thermal_alarm_valid(valid),
        .temp_sense_shutdown_reset(shut), .regulator_ready(ready),
        .chan_current_raw(raw), .ocp_sum_limit(ocp_lim),
        .chan_current_comp(cur), .droop_current(droop), .ocp_trip(ocp),
        .temp_code(tcode), .comp_gain(gain));

    // Clock and watchdog
    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end
    initial begin
        repeat (5000) @(posedge ref_clk);
        n_mismatch++;
        tally_and_finish();
    end

    // Main sequence
    initial begin
        logic [7:0] d;
        rst = 1'b1;
        {ctrl_enable, ready_request, cmd_wr, cmd_rd} = 4'h0;
        {cmd_code, cmd_wdata} = 16'h0000;
        ratio_set = 14'h1388;
        mv_set = 12'h4b0;
        raw = '0;
        ocp_lim = 15'h0000;
        void'($urandom(16788));
        cyc(6);
        rst = 1'b0;
        rd_chk(8'he8, 8'h03);
        rd_chk(8'he9, 8'h00);
        d = 8'($urandom);
        wr(8'h5a, d);
        rd_chk(8'h5a, 8'h00);
        wr(8'he9, d);
        rd_chk(8'he9, d);
        ctrl_enable = 1'b1;
        for (int l = 0; l < 8; l++) begin
            wr(8'he8, {5'($urandom), 3'(l)});
            alarm_step(ON_T[l] - 1, 1'b1);
            alarm_step(OFF_T[l], 1'b1);
            alarm_step(OFF_T[l] + 1, 1'b0);
            alarm_step(ON_T[l], 1'b0);
        end
        alarm_step(256, 1'b1);
        chk("thermal_alarm_valid", 32'h1, 32'(valid));
        ctrl_enable = 1'b0;
        alarm_step(256, 1'b0);
        chk("thermal_alarm_valid", 32'h0, 32'(valid));
        ctrl_enable = 1'b1;
        ready_request = 1'b1;
        foreach (UV_MV[i]) uv_step(UV_MV[i], UV_SD[i]);
        foreach (BP_T[i]) begin
            ratio_set = 14'(BP_T[i] - 1); // Just inside, not on the tie
            cyc(70);
            chk("temp_code", 32'(8 * i), 32'(tcode));
        end
        for (int k = 0; k < 16; k++) begin
            wr(8'he9, {4'($urandom), 4'(k)});
            cyc(2);
            chk("comp_gain", 32'(gain_exp(56, k)), 32'(gain));
        end
        ratio_set = 14'(BP_T[0]);
        wr(8'he9, 8'h01);
        cyc(70);
        for (int t = 0; t < 24; t++) begin
            foreach (raw[i]) raw[i] = (t == 0) ? 12'hfff : 12'($urandom);
            ocp_lim = 15'($urandom_range(24570));
            cyc(4);
            s = 0;
            foreach (raw[i]) begin
                e = cur_exp(raw[i], gain_exp(0, 1));
                s += int'(e);
                chk("chan_current_comp", 32'(e), 32'(cur[i]));
            end
            chk("droop_current", 32'(s), 32'(droop));
            chk("ocp_trip", 32'(s > int'(ocp_lim)), 32'(ocp));
        end
        rst = 1'b1;
        cyc(3);
        rst = 1'b0;
        rd_chk(8'he8, 8'h03);
        rd_chk(8'he9, 8'h00);
        tally_and_finish();
    end
endmodule

bind tmc_thermal tmc_thermal_asserts u_tmc_thermal_asserts (
    .ref_clk(ref_clk), .rst(rst), .temp_sense_input(temp_sense_input),
    .temp_sense_mv(temp_sense_mv), .ctrl_enable(ctrl_enable),
    .cmd_wr(cmd_wr), .cmd_code(cmd_code), .cmd_wdata(cmd_wdata),
    .thermal_alarm_n_o(thermal_alarm_n_o),
    .thermal_alarm_n_oe(thermal_alarm_n_oe),
    .temp_sense_shutdown_reset(temp_sense_shutdown_reset),
    .regulator_ready(regulator_ready), .temp_code(temp_code),
    .comp_gain(comp_gain));
